//--- verilog/sideband_command_engine.sv
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
// Function
// R1: all sideband packets carry header 0b10
// R2: command opens with control packet opcode
// R3: every listed command gets its reply
// R4: requester honours peer sub-command support bits
// R5: state query returns capability byte zero
// R6: capability valid only after ready flag
// R7: maker query returns one eight-bit byte
// R8: only sink or dongle sends hot-plug
// R9: hot-plug set waits minimum gap after clear
// R10: display error codes 00,01,02,04
// R11: sideband codes add 08,10,20
// R12: last-error register overwritten on every error
// R13: capability read sends one offset packet
// R14: good capability read: ACK then byte
// R15: bad capability offset: ABORT, no data
// R16: source re-reads capabilities after change irq
// R17: adopter_identifier read before burst write
// R18: status/interrupt write: offset then value
// R19: status write replaces all eight bits
// R20: interrupt set only ORs bits in
// R21: status offset out of range aborts
// R22: interrupt offset out of range aborts
// R23: fixed control codes and opcodes
// R24: shared opcode split by offset range
// R25: bad offset: ABORT, code 10, idle
// R26: last-error registers reset to zero
module sideband_command_engine #(
  parameter int timeout_cyc = sideband_pkg::cmd_timeout_cyc
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // packets received from the link layer (same clock)
  input  wire logic        rx_valid,
  input  wire logic [1:0]  rx_chan,
  input  wire logic        rx_ctrl,
  input  wire logic [7:0]  rx_byte,
  // packets handed to the link layer
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [1:0]       tx_chan,
  output logic             tx_ctrl,
  output logic [7:0]       tx_byte,
  // pulse when a peer hot-plug command arrives and the engine is not busy
  output logic             hp_assert_evt,
  output logic             hp_deassert_evt
);
  typedef enum {s_idle, s_off, s_val, s_reply, s_data} st_t;
  typedef struct packed {
    st_t        st;          // responder state
    logic [7:0] op;          // opcode being served
    logic [7:0] off;         // received offset
    logic [7:0] dbyte;       // data byte to follow ACK
    logic       send_data;   // ACK is followed by a data packet
    logic       tx_ctrl;     // packet kind to send
    logic [7:0] tx_byte;     // packet byte to send
    logic [15:0] tmo;        // command timeout counter
    logic [7:0] side_err;    // last sideband error
    logic [7:0] disp_err;    // last display-channel error
    logic       cap_ready;   // local capability ready
    logic       busy;        // software marks engine busy
    logic [7:0] maker;       // maker code
    logic [15:0][7:0] cap;   // capability bytes
    logic [3:0][7:0]  ints;  // interrupt bytes
    logic [3:0][7:0]  stat;  // status bytes
    logic       hp_set;      // hot-plug set pulse
    logic       hp_clr;      // hot-plug clear pulse
    logic [31:0] rdata;      // apb read data
  } state_t;

  state_t cur;       // registered state
  state_t next_cur;  // next state

  logic   rx_mine;   // packet for the sideband channel
  logic   wr_en;     // apb write strobe
  logic   rd_en;     // apb read strobe
  logic   in_cap;    // offset hits capability space
  logic   in_int;    // offset hits interrupt space
  logic   in_stat;   // offset hits status space
  logic   map_hit;   // apb address decoded

  assign rx_mine = rx_valid && (rx_chan == sideband_pkg::chan_sideband);  // [R1]
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign in_cap  = cur.off >= sideband_pkg::cap_base && cur.off <= sideband_pkg::cap_last;
  assign in_int  = cur.off >= sideband_pkg::int_base && cur.off <= sideband_pkg::int_last;
  assign in_stat = cur.off >= sideband_pkg::stat_base && cur.off <= sideband_pkg::stat_last;
  assign map_hit = paddr[1:0] == 2'h0 && (paddr <= sideband_pkg::a_side_err
                   || (paddr >= sideband_pkg::a_cap_win && paddr < sideband_pkg::a_int_win)
                   || (paddr >= sideband_pkg::a_int_win && paddr < 8'ha0));

  // apb answers in the access cycle, zero wait states
  assign pready  = 1'b1;
  assign pslverr = (wr_en || rd_en) && !map_hit;
  assign prdata  = cur.rdata;

  // packets out: handshake is combinational, contents registered
  // requester-side timing stays with software: nothing here starts a command
  assign tx_valid = (cur.st == s_reply) || (cur.st == s_data);  // replies only [R8] [R9] [R17]
  assign tx_chan  = sideband_pkg::chan_sideband;  // [R1]
  assign tx_ctrl  = cur.tx_ctrl;
  assign tx_byte  = cur.tx_byte;
  assign hp_assert_evt   = cur.hp_set;
  assign hp_deassert_evt = cur.hp_clr;

  // all next-state logic
  always_comb begin
    next_cur = cur;
    next_cur.hp_set = 1'b0;
    next_cur.hp_clr = 1'b0;
    // software side: read data is captured in the setup cycle for the access cycle
    if (psel && !penable) begin
      next_cur.rdata = 32'h0;
      if (!map_hit) begin
        // unmapped or unaligned reads return zero, not a window byte
        next_cur.rdata = 32'h0;
      end else if (paddr == sideband_pkg::a_ctrl) begin
        next_cur.rdata = {29'h0, cur.st != s_idle, cur.busy, cur.cap_ready};
      end else if (paddr == sideband_pkg::a_maker) begin
        next_cur.rdata = {24'h0, cur.maker};
      end else if (paddr == sideband_pkg::a_disp_err) begin
        next_cur.rdata = {24'h0, cur.disp_err};
      end else if (paddr == sideband_pkg::a_side_err) begin
        next_cur.rdata = {24'h0, cur.side_err};
      end else if (paddr >= sideband_pkg::a_cap_win && paddr < sideband_pkg::a_int_win) begin
        next_cur.rdata = {24'h0, cur.cap[paddr[5:2]]};
      end else if (paddr >= sideband_pkg::a_int_win && paddr < sideband_pkg::a_stat_win) begin
        next_cur.rdata = {24'h0, cur.ints[paddr[3:2]]};
      end else if (paddr >= sideband_pkg::a_stat_win && paddr < 8'ha0) begin
        next_cur.rdata = {24'h0, cur.stat[paddr[3:2]]};
      end
    end
    if (wr_en && paddr[1:0] == 2'h0) begin
      if (paddr == sideband_pkg::a_ctrl) begin
        next_cur.cap_ready = pwdata[0];  // [R6]
        next_cur.busy      = pwdata[1];
      end else if (paddr == sideband_pkg::a_maker) begin
        next_cur.maker = pwdata[7:0];
      end else if (paddr == sideband_pkg::a_disp_err) begin
        next_cur.disp_err = pwdata[7:0];  // [R10] [R12]
      end else if (paddr >= sideband_pkg::a_cap_win && paddr < sideband_pkg::a_int_win) begin
        next_cur.cap[paddr[5:2]] = pwdata[7:0];
      end else if (paddr >= sideband_pkg::a_int_win && paddr < sideband_pkg::a_stat_win) begin
        // software clears interrupt bits by writing ones
        next_cur.ints[paddr[3:2]] = cur.ints[paddr[3:2]] & ~pwdata[7:0];
      end else if (paddr >= sideband_pkg::a_stat_win && paddr < 8'ha0) begin
        next_cur.stat[paddr[3:2]] = pwdata[7:0];
      end
    end
    // command timeout runs whenever a command is half received
    // so a requester that stalls mid-command never wedges the responder
    if (cur.st == s_off || cur.st == s_val) begin
      next_cur.tmo = cur.tmo + 16'h1;
      if (cur.tmo == 16'(timeout_cyc - 1)) begin
        next_cur.st       = s_idle;
        next_cur.side_err = sideband_pkg::err_timeout;  // [R11] [R12]
      end
    end else begin
      next_cur.tmo = 16'h0;
    end
    unique case (cur.st)
      s_idle: begin
        if (rx_mine && !rx_ctrl) begin
          // data packet cannot start a command
          next_cur.side_err = sideband_pkg::err_opcode;  // [R2] [R11]
          next_cur.tx_ctrl  = 1'b1;
          next_cur.tx_byte  = sideband_pkg::code_abort;
          next_cur.send_data = 1'b0;
          next_cur.st       = s_reply;
        end else if (rx_mine) begin
          next_cur.op        = rx_byte;
          next_cur.tx_ctrl   = 1'b1;
          next_cur.tx_byte   = sideband_pkg::code_ack;
          next_cur.send_data = 1'b1;
          next_cur.st        = s_reply;
          // busy engine refuses new work with NACK and code 20
          if (cur.busy) begin
            next_cur.tx_byte   = sideband_pkg::code_nack;
            next_cur.send_data = 1'b0;
            next_cur.side_err  = sideband_pkg::err_busy;  // [R11] [R12]
          end else begin
            unique case (rx_byte)  // [R3] [R23]
              sideband_pkg::op_state_q:    next_cur.dbyte = cur.cap[0];  // [R5]
              sideband_pkg::op_maker_q:    next_cur.dbyte = cur.maker;  // [R7]
              sideband_pkg::op_disp_err_q: next_cur.dbyte = cur.disp_err;  // [R10]
              sideband_pkg::op_side_err_q: next_cur.dbyte = cur.side_err;  // [R12]
              sideband_pkg::op_hp_assert: begin
                next_cur.send_data = 1'b0;
                next_cur.hp_set    = 1'b1;
              end
              sideband_pkg::op_hp_deassert: begin
                next_cur.send_data = 1'b0;
                next_cur.hp_clr    = 1'b1;
              end
              sideband_pkg::op_cap_read,
              sideband_pkg::op_stat_int:   next_cur.st = s_off;  // [R13] [R18]
              default: begin
                next_cur.tx_byte   = sideband_pkg::code_abort;
                next_cur.send_data = 1'b0;
                next_cur.side_err  = sideband_pkg::err_opcode;  // [R11]
              end
            endcase
          end
        end
      end
      s_off: begin
        if (rx_mine && rx_ctrl) begin
          // control where a data packet belongs
          next_cur.side_err  = sideband_pkg::err_protocol;
          next_cur.tx_byte   = sideband_pkg::code_abort;
          next_cur.send_data = 1'b0;
          next_cur.st        = s_reply;
        end else if (rx_mine) begin
          next_cur.off = rx_byte;
          next_cur.st  = (cur.op == sideband_pkg::op_cap_read) ? s_reply : s_val;
          if (cur.op == sideband_pkg::op_cap_read) begin
            if (rx_byte <= sideband_pkg::cap_last) begin
              next_cur.dbyte = cur.cap[rx_byte[3:0]];  // [R14]
            end else begin
              next_cur.tx_byte   = sideband_pkg::code_abort;  // [R15] [R25]
              next_cur.send_data = 1'b0;
              next_cur.side_err  = sideband_pkg::err_offset;
            end
          end
        end
      end
      s_val: begin
        if (rx_mine && rx_ctrl) begin
          next_cur.side_err  = sideband_pkg::err_protocol;
          next_cur.tx_byte   = sideband_pkg::code_abort;
          next_cur.send_data = 1'b0;
          next_cur.st        = s_reply;
        end else if (rx_mine) begin
          next_cur.st        = s_reply;
          next_cur.send_data = 1'b0;
          if (in_stat) begin
            next_cur.stat[cur.off[1:0]] = rx_byte;  // [R19] [R24]
          end else if (in_int) begin
            // ORed after any software clear, so a set in the same cycle wins
            next_cur.ints[cur.off[1:0]] = next_cur.ints[cur.off[1:0]] | rx_byte;  // [R20] [R24]
          end else begin
            next_cur.tx_byte  = sideband_pkg::code_abort;  // [R21] [R22] [R25]
            next_cur.side_err = sideband_pkg::err_offset;
          end
        end
      end
      s_reply: begin
        // the reply packet stands until the link layer takes it
        if (tx_ready) begin
          next_cur.st = cur.send_data ? s_data : s_idle;
          next_cur.tx_ctrl = 1'b0;
          next_cur.tx_byte = cur.dbyte;
        end
      end
      s_data: begin
        if (tx_ready) begin
          next_cur.st = s_idle;
        end
      end
    endcase
  end

  // one register for all state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur          <= '0;
      cur.st       <= s_idle;
      cur.maker    <= sideband_pkg::maker_reset;
      cur.side_err <= sideband_pkg::err_none;  // [R26]
      cur.disp_err <= sideband_pkg::err_none;  // [R26]
    end else begin
      cur <= next_cur;
    end
  end

  // bad capability offset gives abort and no data
  property p_cap_abort;
    @(posedge sys_clk) disable iff (rst)
      (cur.st == s_off && cur.op == sideband_pkg::op_cap_read && rx_mine && !rx_ctrl
       && rx_byte > sideband_pkg::cap_last)
      |=> (tx_valid && tx_byte == sideband_pkg::code_abort && !cur.send_data);
  endproperty
  a_cap_abort: assert property (p_cap_abort) else $error("capability abort missing");  // [R15]

  // interrupt set leaves every bit it carries set
  property p_int_or;
    @(posedge sys_clk) disable iff (rst)
      (cur.st == s_val && rx_mine && !rx_ctrl && in_int && !wr_en)
      |=> ((cur.ints[$past(cur.off[1:0])] & $past(rx_byte)) == $past(rx_byte));
  endproperty
  a_int_or: assert property (p_int_or) else $error("interrupt set lost a bit");  // [R20]

  // status write replaces the byte
  property p_stat_wr;
    @(posedge sys_clk) disable iff (rst)
      (cur.st == s_val && rx_mine && !rx_ctrl && in_stat && !wr_en)
      |=> (cur.stat[$past(cur.off[1:0])] == $past(rx_byte));
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status byte not replaced");  // [R19]

  // bad write offset records code 10
  property p_bad_off;
    @(posedge sys_clk) disable iff (rst)
      (cur.st == s_val && rx_mine && !rx_ctrl && !in_int && !in_stat)
      |=> (cur.side_err == sideband_pkg::err_offset && tx_byte == sideband_pkg::code_abort);
  endproperty
  a_bad_off: assert property (p_bad_off) else $error("bad offset not aborted");  // [R25]

  // in-range status write is acknowledged
  property p_no_abort;
    @(posedge sys_clk) disable iff (rst)
      (cur.st == s_val && rx_mine && !rx_ctrl && (in_int || in_stat))
      |=> (tx_byte == sideband_pkg::code_ack);
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("in-range write aborted");  // [R21] [R22]

  // state query returns capability byte zero after ack
  sequence s_ack_out;
    tx_valid && tx_ctrl && tx_byte == sideband_pkg::code_ack && tx_ready;
  endsequence
  property p_state_q;
    @(posedge sys_clk) disable iff (rst)
      (cur.st == s_reply && cur.op == sideband_pkg::op_state_q && cur.send_data) ##0 s_ack_out
      |=> (!tx_ctrl && tx_byte == cur.cap[0] && tx_valid);
  endproperty
  a_state_q: assert property (p_state_q) else $error("state query reply wrong");  // [R5]

  // all outgoing packets use the sideband header
  property p_chan;
    @(posedge sys_clk) disable iff (rst) tx_valid |-> tx_chan == sideband_pkg::chan_sideband;
  endproperty
  a_chan: assert property (p_chan) else $error("wrong channel header");  // [R1]

  // data packet at command start is refused with abort
  property p_lead_data;
    @(posedge sys_clk) disable iff (rst)
      (cur.st == s_idle && rx_mine && !rx_ctrl)
      |=> (tx_byte == sideband_pkg::code_abort && cur.side_err == sideband_pkg::err_opcode);
  endproperty
  a_lead_data: assert property (p_lead_data) else $error("leading data not refused");  // [R2]

  // packets on another header never start a command
  property p_foreign;
    @(posedge sys_clk) disable iff (rst)
      (cur.st == s_idle && rx_valid && rx_chan != sideband_pkg::chan_sideband) |=> (cur.st == s_idle);
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign packet accepted");  // [R1]

  // good capability read: the byte follows the accepted ACK
  property p_cap_good;
    @(posedge sys_clk) disable iff (rst)
      (cur.st == s_reply && cur.op == sideband_pkg::op_cap_read && cur.send_data && in_cap && tx_ready)
      |=> (tx_valid && !tx_ctrl && tx_byte == cur.cap[cur.off[3:0]]);
  endproperty
  a_cap_good: assert property (p_cap_good) else $error("capability byte wrong");  // [R14]

  // busy engine answers NACK and records code 20
  property p_busy_nack;
    @(posedge sys_clk) disable iff (rst)
      (cur.st == s_idle && rx_mine && rx_ctrl && cur.busy)
      |=> (tx_byte == sideband_pkg::code_nack && cur.side_err == sideband_pkg::err_busy);
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("busy not refused");  // [R11] [R12]
endmodule

//--- verilog/sideband_pkg.sv
package sideband_pkg;
  // link-layer channel header and packet kind
  localparam logic [1:0] chan_sideband = 2'h2;  // sideband channel header
  localparam logic       kind_control  = 1'h1;  // control packet flag
  // control packet codes
  localparam logic [7:0] code_ack      = 8'h33;
  localparam logic [7:0] code_nack     = 8'h34;
  localparam logic [7:0] code_abort    = 8'h35;
  // opcodes
  localparam logic [7:0] op_stat_int   = 8'h60;  // status write / interrupt set
  localparam logic [7:0] op_cap_read   = 8'h61;
  localparam logic [7:0] op_state_q    = 8'h62;
  localparam logic [7:0] op_maker_q    = 8'h63;
  localparam logic [7:0] op_hp_assert  = 8'h64;
  localparam logic [7:0] op_hp_deassert = 8'h65;
  localparam logic [7:0] op_disp_err_q = 8'h6a;
  localparam logic [7:0] op_side_err_q = 8'h6b;
  // error codes
  localparam logic [7:0] err_none      = 8'h00;
  localparam logic [7:0] err_retry     = 8'h01;
  localparam logic [7:0] err_protocol  = 8'h02;
  localparam logic [7:0] err_timeout   = 8'h04;
  localparam logic [7:0] err_opcode    = 8'h08;
  localparam logic [7:0] err_offset    = 8'h10;
  localparam logic [7:0] err_busy      = 8'h20;
  // offset ranges of the local register spaces
  localparam logic [7:0] cap_base      = 8'h00;
  localparam logic [7:0] cap_last      = 8'h0f;
  localparam logic [7:0] int_base      = 8'h20;
  localparam logic [7:0] int_last      = 8'h23;
  localparam logic [7:0] stat_base     = 8'h30;
  localparam logic [7:0] stat_last     = 8'h33;
  // apb register byte addresses
  localparam logic [7:0] a_ctrl        = 8'h00;  // bit0 cap ready, bit1 busy
  localparam logic [7:0] a_maker       = 8'h04;
  localparam logic [7:0] a_disp_err    = 8'h08;  // write: record display error
  localparam logic [7:0] a_side_err    = 8'h0c;  // read only
  localparam logic [7:0] a_cap_win     = 8'h40;  // 16 words of capability bytes
  localparam logic [7:0] a_int_win     = 8'h80;  // 4 words interrupt bytes
  localparam logic [7:0] a_stat_win    = 8'h90;  // 4 words status bytes
  localparam logic [7:0] maker_reset   = 8'h5a;  // arbitrary maker code
  // command timeout in cycles of the 100 ns clock
  localparam int         cmd_timeout_us = 100;
  localparam int         clk_mhz        = 10;
  localparam int         cmd_timeout_cyc = cmd_timeout_us * clk_mhz;
endpackage

//--- sim/sideband_peer.sv
`timescale 1ns/1ps
// far-side requester: sends command packets and collects the replies
// it sends no message sub-commands, so no support bit is ignored
module sideband_peer (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       slow,      // stall replies on every other cycle
  input  wire logic       tx_valid,
  input  wire logic [1:0] tx_chan,
  input  wire logic       tx_ctrl,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [1:0]      rx_chan,
  output logic            rx_ctrl,
  output logic [7:0]      rx_byte
);
  logic [10:0] rq[$];  // replies seen, as {chan, ctrl, byte}

  // lines start idle, off the sideband header
  initial begin
    rx_valid = 1'b0;
    rx_chan  = 2'h1;
    rx_ctrl  = 1'b0;
    rx_byte  = 8'h00;
  end

  // one packet; afterwards the lines show the inverse so a stale value never passes
  task automatic send(input logic [1:0] ch, input logic c, input logic [7:0] b);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_chan  <= ch;
    rx_ctrl  <= c;
    rx_byte  <= b;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_chan  <= ~ch;
    rx_ctrl  <= ~c;
    rx_byte  <= ~b;
  endtask

  // ready toggles when slow, so the engine must hold each reply packet
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
  end

  // a reply packet is taken at an edge where valid and ready are both high
  always @(posedge sys_clk) begin
    if (!rst && tx_valid === 1'b1 && tx_ready) begin
      rq.push_back({tx_chan, tx_ctrl, tx_byte});
    end
  end
endmodule

//--- sim/sideband_command_engine_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
  checked++; \
  if ((gt) !== (ex)) begin \
    fail_count++; \
    $display("mismatch %s exp %h got %h", nm, ex, gt); \
  end \
end
// bench: apb master plus far-side requester
module sideband_command_engine_tb;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err;          // pslverr taken with the last transfer
  logic        tx_valid, tx_ready, tx_ctrl, rx_valid, rx_ctrl, hp_on_evt, hp_off_evt;
  logic [1:0]  tx_chan, rx_chan;
  logic [7:0]  tx_byte, rx_byte;
  int          checked, fail_count, hp_on, hp_off;
  logic [7:0]  bad[4] = '{8'h1f, 8'h24, 8'h2f, 8'h34};  // outside both write ranges
  logic [7:0]  dcode[4] = '{8'h01, 8'h02, 8'h04, 8'h00};

  // short timeout keeps the stalled-command case brief
  sideband_command_engine #(.timeout_cyc(20)) u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_chan(rx_chan), .rx_ctrl(rx_ctrl),
    .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_chan(tx_chan), .tx_ctrl(tx_ctrl),
    .tx_byte(tx_byte), .hp_assert_evt(hp_on_evt), .hp_deassert_evt(hp_off_evt));
  sideband_peer u_peer (.sys_clk(sys_clk), .rst(rst), .slow(slow), .tx_valid(tx_valid),
    .tx_chan(tx_chan), .tx_ctrl(tx_ctrl), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_chan(rx_chan), .rx_ctrl(rx_ctrl), .rx_byte(rx_byte));

  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // count hot-plug pulses, one per command expected
  always @(posedge sys_clk) begin
    if (hp_on_evt === 1'b1) hp_on++;
    if (hp_off_evt === 1'b1) hp_off++;
  end

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // next reply packet must be {ctrl, byte} on the sideband header
  task automatic reply(input logic [8:0] e);
    int          n;
    logic [10:0] got;
    n = 0;
    while (u_peer.rq.size() == 0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    got = (u_peer.rq.size() > 0) ? u_peer.rq.pop_front() : 11'h7ff;
    `CHK("reply", {sideband_pkg::chan_sideband, e}, got)
  endtask

  // command: opcode control packet, then n data packets
  task automatic cmd(input logic [7:0] op, input int n, input logic [7:0] d0, input logic [7:0] d1);
    u_peer.send(2'h2, 1'b1, op);
    if (n > 0) u_peer.send(2'h2, 1'b0, d0);
    if (n > 1) u_peer.send(2'h2, 1'b0, d1);
  endtask

  // single-byte query: ack then the byte
  task automatic query(input logic [7:0] op, input logic [7:0] ex);
    cmd(op, 0, 8'h00, 8'h00);
    reply({1'b1, sideband_pkg::code_ack});
    reply({1'b0, ex});
  endtask

  // sideband last-error register over apb
  task automatic err_is(input logic [7:0] code);
    apb(1'b0, sideband_pkg::a_side_err, 32'h0);
    `CHK("side_err", {24'h0, code}, rd)
    `CHK("side_err_ok", 1'b0, err)
  endtask

  // nothing may come back for k cycles
  task automatic quiet(input int k);
    repeat (k) @(posedge sys_clk);
    `CHK("quiet", 0, u_peer.rq.size())
  endtask

  task automatic give_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, slow, err} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    err_is(sideband_pkg::err_none);
    apb(1'b0, sideband_pkg::a_disp_err, 32'h0);
    `CHK("disp_err", 32'h0, rd)
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped", 1'b1, err)
    $display("test reset done");
    // capability bytes 0 and 15, ready flag up; peer stalls replies to the first two queries
    apb(1'b1, sideband_pkg::a_ctrl, 32'h1);
    apb(1'b0, sideband_pkg::a_ctrl, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    apb(1'b1, sideband_pkg::a_cap_win, 32'h3c);
    apb(1'b1, 8'h7c, 32'ha5);
    slow <= 1'b1;
    query(sideband_pkg::op_state_q, 8'h3c);
    query(sideband_pkg::op_maker_q, sideband_pkg::maker_reset);
    slow <= 1'b0;
    cmd(sideband_pkg::op_cap_read, 1, 8'h0f, 8'h00);
    reply({1'b1, sideband_pkg::code_ack});
    reply({1'b0, 8'ha5});
    apb(1'b1, 8'h7c, 32'h5b);
    cmd(sideband_pkg::op_cap_read, 1, 8'h0f, 8'h00);
    reply({1'b1, sideband_pkg::code_ack});
    reply({1'b0, 8'h5b});
    cmd(sideband_pkg::op_cap_read, 1, 8'h10, 8'h00);
    reply({1'b1, sideband_pkg::code_abort});
    query(sideband_pkg::op_side_err_q, sideband_pkg::err_offset);
    $display("test queries done");
    // shared opcode: status replaced whole, interrupt only ORed
    cmd(sideband_pkg::op_stat_int, 2, 8'h33, 8'hf0);
    reply({1'b1, sideband_pkg::code_ack});
    cmd(sideband_pkg::op_stat_int, 2, 8'h33, 8'h0f);
    reply({1'b1, sideband_pkg::code_ack});
    apb(1'b0, 8'h9c, 32'h0);
    `CHK("stat3", 32'h0f, rd)
    cmd(sideband_pkg::op_stat_int, 2, 8'h20, 8'h81);
    reply({1'b1, sideband_pkg::code_ack});
    cmd(sideband_pkg::op_stat_int, 2, 8'h20, 8'h02);
    reply({1'b1, sideband_pkg::code_ack});
    apb(1'b0, sideband_pkg::a_int_win, 32'h0);
    `CHK("int0", 32'h83, rd)
    apb(1'b1, sideband_pkg::a_int_win, 32'h01);
    apb(1'b0, sideband_pkg::a_int_win, 32'h0);
    `CHK("int0_clr", 32'h82, rd)
    foreach (bad[i]) begin
      cmd(sideband_pkg::op_stat_int, 2, bad[i], 8'hff);
      reply({1'b1, sideband_pkg::code_abort});
    end
    err_is(sideband_pkg::err_offset);
    $display("test writes done");
    // faults, each overwriting the last-error register
    cmd(8'h66, 0, 8'h00, 8'h00);
    reply({1'b1, sideband_pkg::code_abort});
    err_is(sideband_pkg::err_opcode);
    u_peer.send(2'h2, 1'b0, 8'h61);
    reply({1'b1, sideband_pkg::code_abort});
    err_is(sideband_pkg::err_opcode);
    cmd(sideband_pkg::op_cap_read, 0, 8'h00, 8'h00);
    u_peer.send(2'h2, 1'b1, sideband_pkg::op_state_q);
    reply({1'b1, sideband_pkg::code_abort});
    err_is(sideband_pkg::err_protocol);
    apb(1'b1, sideband_pkg::a_ctrl, 32'h3);
    cmd(sideband_pkg::op_state_q, 0, 8'h00, 8'h00);
    reply({1'b1, sideband_pkg::code_nack});
    apb(1'b1, sideband_pkg::a_ctrl, 32'h1);
    err_is(sideband_pkg::err_busy);
    cmd(sideband_pkg::op_cap_read, 0, 8'h00, 8'h00);
    apb(1'b0, sideband_pkg::a_ctrl, 32'h0);
    `CHK("active", 32'h5, rd)
    quiet(30);
    err_is(sideband_pkg::err_timeout);
    $display("test faults done");
    // display-channel codes, hot-plug pulses, foreign channel ignored
    foreach (dcode[i]) begin
      apb(1'b1, sideband_pkg::a_disp_err, {24'h0, dcode[i]});
      query(sideband_pkg::op_disp_err_q, dcode[i]);
    end
    cmd(sideband_pkg::op_hp_assert, 0, 8'h00, 8'h00);
    reply({1'b1, sideband_pkg::code_ack});
    @(posedge sys_clk);
    `CHK("hp_on", 1, hp_on)
    cmd(sideband_pkg::op_hp_deassert, 0, 8'h00, 8'h00);
    reply({1'b1, sideband_pkg::code_ack});
    @(posedge sys_clk);
    `CHK("hp_off", 1, hp_off)
    u_peer.send(2'h1, 1'b1, sideband_pkg::op_state_q);
    quiet(10);
    $display("test misc done");
    give_verdict();
  end
endmodule
